/* File: rtl/ccpms_params.svh */
`ifndef CCPMS_PARAMS_SVH
`define CCPMS_PARAMS_SVH
// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define CCPMS_NCH 10
`define CCPMS_NTMR 5
// ---------------------------------------------------------------
// Mode codes
// ---------------------------------------------------------------
`define CCPMS_M_OFF 4'h0
`define CCPMS_M_TOGGLE 4'h2
`define CCPMS_M_CAP_FALL 4'h4
`define CCPMS_M_CAP_RISE 4'h5
`define CCPMS_M_CAP_4 4'h6
`define CCPMS_M_CAP_16 4'h7
`define CCPMS_M_SET 4'h8
`define CCPMS_M_CLR 4'h9
`define CCPMS_M_SWINT 4'ha
`define CCPMS_M_SPECIAL 4'hb
`define CCPMS_M_PWM_TOP 2'h3
`define CCPMS_PRE4_LAST 4'h3
`define CCPMS_PRE16_LAST 4'hf
`define CCPMS_PRE_ONE 4'h1
// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define CCPMS_MODE_LSB 0
`define CCPMS_DUTY_LSB 4
`define CCPMS_CTL_WMASK 8'h3f
`define CCPMS_TSEL2_WMASK 8'h0f
// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define CCPMS_A_CH_END 8'h28
`define CCPMS_F_CTL 2'h0
`define CCPMS_F_RL 2'h1
`define CCPMS_F_RH 2'h2
`define CCPMS_A_TSEL0 8'h40
`define CCPMS_A_TSEL1 8'h41
`define CCPMS_A_TSEL2 8'h42
`define CCPMS_A_FLAG_LO 8'h44
`define CCPMS_A_FLAG_HI 8'h45
`define CCPMS_A_MASK_LO 8'h46
`define CCPMS_A_MASK_HI 8'h47
// ---------------------------------------------------------------
// Period timer indices
// ---------------------------------------------------------------
`define CCPMS_T2 3'h0
`define CCPMS_T4 3'h1
`define CCPMS_T6 3'h2
`define CCPMS_T8 3'h3
`define CCPMS_T10 3'h4
`endif

/* File: rtl/ccpms_pkg.sv */
package ccpms_pkg;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] rl;
    logic [7:0] rh;
    logic [9:0] duty;
    logic [3:0] pre;
    logic out;
    logic match;
    logic in_prev;
  } ccpms_ch_t;

  typedef struct packed {
    logic tick;
    logic [7:0] period;
    logic [9:0] base;
  } ccpms_tmr_t;

  typedef struct packed {
    ccpms_ch_t [9:0] ch;
    logic [2:0][7:0] tsel;
    logic [9:0] flags;
    logic [9:0] mask;
    logic [9:0] sync1;
    logic [9:0] sync2;
    logic [7:0] rdata;
    logic [4:0] tclr;
    logic adc;
  } ccpms_state_t;
endpackage : ccpms_pkg

/* File: rtl/ccpms_top.sv */
`timescale 1ns/1ps
`include "ccpms_params.svh"
`default_nettype none
module ccpms_top
  import ccpms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [9:0] ccp_in,
  output logic [9:0] ccp_out,
  output logic [9:0] ccp_oe,
  input wire logic [15:0] t1_cnt,
  input wire logic [15:0] t5_cnt,
  input wire ccpms_tmr_t [4:0] pwm_tmr,
  output logic [4:0] timer_clear,
  input wire logic adc_en,
  output logic adc_start,
  output logic irq
);
  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] tsel_of(input logic [2:0][7:0] ts, input int i);
    return ts[i / 4][(i % 4) * 2 +: 2];
  endfunction : tsel_of

  // Returns {valid, timer index}; code 11 is reserved and yields no timer
  function automatic logic [3:0] pwm_map(input int i, input logic [1:0] s);
    logic [2:0] t;
    t = `CCPMS_T2;
    if (s == 2'h1) begin
      t = (i < 4) ? `CCPMS_T4 : (i < 8) ? `CCPMS_T6 : `CCPMS_T8;
    end else if (s == 2'h2) begin
      t = (i < 4) ? `CCPMS_T6 : (i < 8) ? `CCPMS_T8 : `CCPMS_T10;
    end
    return {s != 2'h3, t};
  endfunction : pwm_map

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == `CCPMS_M_PWM_TOP;
  endfunction : is_pwm

  function automatic logic drives(input logic [3:0] m);
    return is_pwm(m) || m == `CCPMS_M_TOGGLE || m == `CCPMS_M_SET || m == `CCPMS_M_CLR;
  endfunction : drives

  ccpms_state_t s_q;
  ccpms_state_t s_d;
  logic [9:0] cmp_hit;
  logic [9:0] cap_ev;
  logic [9:0] per_hit;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] m;
    logic [1:0] sel;
    logic [15:0] tval;
    logic [3:0] pm;
    logic [2:0] ti;
    logic [9:0] nd;
    logic rise;
    logic fall;
    logic eq;
    m = '0;
    sel = '0;
    tval = '0;
    pm = '0;
    ti = '0;
    nd = '0;
    rise = 1'b0;
    fall = 1'b0;
    eq = 1'b0;
    s_d = s_q;
    cmp_hit = '0;
    cap_ev = '0;
    per_hit = '0;
    s_d.tclr = '0;
    s_d.adc = 1'b0;
    s_d.rdata = '0;
    s_d.sync1 = ccp_in;
    s_d.sync2 = s_q.sync1;
    if (rd) begin
      if (addr < `CCPMS_A_CH_END) begin
        case (addr[1:0])
          `CCPMS_F_CTL: s_d.rdata = s_q.ch[addr[7:2]].ctl;
          `CCPMS_F_RL: s_d.rdata = s_q.ch[addr[7:2]].rl;
          `CCPMS_F_RH: s_d.rdata = s_q.ch[addr[7:2]].rh;
          default: s_d.rdata = '0;
        endcase
      end else begin
        case (addr)
          `CCPMS_A_TSEL0: s_d.rdata = s_q.tsel[0];
          `CCPMS_A_TSEL1: s_d.rdata = s_q.tsel[1];
          `CCPMS_A_TSEL2: s_d.rdata = s_q.tsel[2];
          `CCPMS_A_FLAG_LO: s_d.rdata = s_q.flags[7:0];
          `CCPMS_A_FLAG_HI: s_d.rdata = {6'h00, s_q.flags[9:8]};
          `CCPMS_A_MASK_LO: s_d.rdata = s_q.mask[7:0];
          `CCPMS_A_MASK_HI: s_d.rdata = {6'h00, s_q.mask[9:8]};
          default: s_d.rdata = '0;
        endcase
      end
    end
    // Software writes first, so hardware events below take priority
    if (wr) begin
      if (addr < `CCPMS_A_CH_END) begin
        case (addr[1:0])
          `CCPMS_F_CTL: s_d.ch[addr[7:2]].ctl = wdata & `CCPMS_CTL_WMASK;
          `CCPMS_F_RL: s_d.ch[addr[7:2]].rl = wdata;
          `CCPMS_F_RH: s_d.ch[addr[7:2]].rh = wdata;
          default: ;
        endcase
      end else begin
        case (addr)
          `CCPMS_A_TSEL0: s_d.tsel[0] = wdata;
          `CCPMS_A_TSEL1: s_d.tsel[1] = wdata;
          `CCPMS_A_TSEL2: s_d.tsel[2] = wdata & `CCPMS_TSEL2_WMASK;
          `CCPMS_A_FLAG_LO: s_d.flags[7:0] = s_q.flags[7:0] & ~wdata;
          `CCPMS_A_FLAG_HI: s_d.flags[9:8] = s_q.flags[9:8] & ~wdata[1:0];
          `CCPMS_A_MASK_LO: s_d.mask[7:0] = wdata;
          `CCPMS_A_MASK_HI: s_d.mask[9:8] = wdata[1:0];
          default: ;
        endcase
      end
    end
    for (int i = 0; i < `CCPMS_NCH; i++) begin
      m = s_q.ch[i].ctl[`CCPMS_MODE_LSB +: 4];
      sel = tsel_of(s_q.tsel, i);
      tval = sel[0] ? t5_cnt : t1_cnt;
      eq = tval == {s_q.ch[i].rh, s_q.ch[i].rl};
      rise = s_q.sync2[i] & ~s_q.ch[i].in_prev;
      fall = ~s_q.sync2[i] & s_q.ch[i].in_prev;
      s_d.ch[i].in_prev = s_q.sync2[i];
      s_d.ch[i].match = 1'b0;
      case (m)
        `CCPMS_M_OFF: begin
          s_d.ch[i].out = 1'b0;
          s_d.ch[i].pre = '0;
          s_d.ch[i].duty = '0;
        end
        `CCPMS_M_CAP_FALL: cap_ev[i] = fall;
        `CCPMS_M_CAP_RISE: cap_ev[i] = rise;
        `CCPMS_M_CAP_4, `CCPMS_M_CAP_16: begin
          if (rise) begin
            if (s_q.ch[i].pre == (m == `CCPMS_M_CAP_4 ? `CCPMS_PRE4_LAST : `CCPMS_PRE16_LAST)) begin
              cap_ev[i] = 1'b1;
              s_d.ch[i].pre = '0;
            end else begin
              s_d.ch[i].pre = s_q.ch[i].pre + `CCPMS_PRE_ONE;
            end
          end
        end
        `CCPMS_M_TOGGLE, `CCPMS_M_SET, `CCPMS_M_CLR, `CCPMS_M_SWINT, `CCPMS_M_SPECIAL: begin
          // Timers advance slower than the clock; act on the first equal cycle only
          s_d.ch[i].match = eq;
          cmp_hit[i] = eq & ~s_q.ch[i].match;
          if (cmp_hit[i]) begin
            case (m)
              `CCPMS_M_TOGGLE: s_d.ch[i].out = ~s_q.ch[i].out;
              `CCPMS_M_SET: s_d.ch[i].out = 1'b1;
              `CCPMS_M_CLR: s_d.ch[i].out = 1'b0;
              `CCPMS_M_SPECIAL: s_d.adc = adc_en;
              default: ;
            endcase
            if (m != `CCPMS_M_TOGGLE) begin
              s_d.flags[i] = 1'b1;
            end
          end
        end
        default: begin
          if (is_pwm(m)) begin
            pm = pwm_map(i, sel);
            ti = pm[2:0];
            nd = {s_q.ch[i].rl, s_q.ch[i].ctl[`CCPMS_DUTY_LSB +: 2]};
            if (pm[3]) begin
              if (pwm_tmr[ti].tick && pwm_tmr[ti].base[9:2] == pwm_tmr[ti].period) begin
                per_hit[i] = 1'b1;
                s_d.tclr[ti] = 1'b1;
                s_d.ch[i].duty = nd;
                s_d.ch[i].out = nd != '0;
              end else if (pwm_tmr[ti].base == s_q.ch[i].duty) begin
                s_d.ch[i].out = 1'b0;
              end
            end
          end
        end
      endcase
      if (cap_ev[i]) begin
        s_d.ch[i].rl = tval[7:0];
        s_d.ch[i].rh = tval[15:8];
        s_d.flags[i] = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    for (int i = 0; i < `CCPMS_NCH; i++) begin
      ccp_out[i] = s_q.ch[i].out;
      ccp_oe[i] = drives(s_q.ch[i].ctl[`CCPMS_MODE_LSB +: 4]);
    end
  end

  assign rdata = s_q.rdata;
  assign timer_clear = s_q.tclr;
  assign adc_start = s_q.adc;
  assign irq = |(s_q.flags & s_q.mask);

  // ---------------------------------------------------------------
  // Checks on channel 0
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic [3:0] m0;
  assign m0 = s_q.ch[0].ctl[`CCPMS_MODE_LSB +: 4];

  sequence s_hit0(logic [3:0] code);
    cmp_hit[0] && m0 == code;
  endsequence

  a_cmp_set_high: assert property (s_hit0(`CCPMS_M_SET) |=> ccp_out[0] && s_q.flags[0])
    else $error("set-on-match failed");
  a_cmp_clr_low: assert property (s_hit0(`CCPMS_M_CLR) |=> !ccp_out[0] && s_q.flags[0])
    else $error("clear-on-match failed");
  a_special_adc: assert property (s_hit0(`CCPMS_M_SPECIAL) ##0 adc_en |=> adc_start ##1 !adc_start)
    else $error("special event did not pulse converter start");
  a_swint_only: assert property (s_hit0(`CCPMS_M_SWINT) |=> s_q.flags[0] && $stable(ccp_out[0]))
    else $error("software-interrupt compare changed output");
  a_cmp_toggle: assert property (s_hit0(`CCPMS_M_TOGGLE) |=> ccp_out[0] != $past(ccp_out[0]))
    else $error("toggle did not toggle");
  a_cap_fall: assert property (m0 == `CCPMS_M_CAP_FALL && s_q.ch[0].in_prev && !s_q.sync2[0]
    |=> s_q.flags[0] && {s_q.ch[0].rh, s_q.ch[0].rl} == $past(s_q.tsel[0][0] ? t5_cnt : t1_cnt))
    else $error("falling edge not captured");
  a_cap_every4: assert property (cap_ev[0] && m0 == `CCPMS_M_CAP_4 |-> s_q.ch[0].pre == `CCPMS_PRE4_LAST)
    else $error("prescaled capture at wrong count");
  a_cap_timer5: assert property (cap_ev[0] && s_q.tsel[0][0] |=> {s_q.ch[0].rh, s_q.ch[0].rl} == $past(t5_cnt))
    else $error("capture did not take Timer5");
  a_pwm_period: assert property (per_hit[0] |=> s_q.ch[0].duty == $past({s_q.ch[0].rl, s_q.ch[0].ctl[5:4]})
    && timer_clear != '0)
    else $error("period match did not latch duty");
  // Enable follows the live mode, so it is checked in the off cycle itself
  a_off_reset: assert property (m0 == `CCPMS_M_OFF |-> !ccp_oe[0] ##1 (!ccp_out[0] && s_q.ch[0].pre == '0
    && s_q.ch[0].duty == '0))
    else $error("off mode left channel state");
endmodule : ccpms_top
`default_nettype wire

/* File: testbench/ccpms_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccpms_far_model
  import ccpms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [4:0] timer_clear,
  output ccpms_tmr_t [4:0] pwm_tmr
);
  logic [4:0][9:0] base_q;
  // ----------------------------------------
  // Period timers, one count per four clocks
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      base_q <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        // Restart only on request, so a missing clear shows as a long period
        base_q[i] <= timer_clear[i] ? 10'h000 : base_q[i] + 10'h001;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pwm_tmr[i].tick = (base_q[i][1:0] == 2'h3);
      pwm_tmr[i].period = 8'h03;
      pwm_tmr[i].base = base_q[i];
    end
  end
endmodule : ccpms_far_model
`default_nettype wire

/* File: testbench/test_ccp_mode_and_timer_select.sv */
`timescale 1ns/1ps
`include "ccpms_params.svh"
`default_nettype none
module test_ccp_mode_and_timer_select
  import ccpms_pkg::*;
  ;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [9:0] ccp_in = 10'h000;
  logic [15:0] t1_cnt = 16'h0000;
  logic [15:0] t5_cnt = 16'h0000;
  logic adc_en = 1'b0;
  logic [7:0] rdata;
  logic [9:0] ccp_out, ccp_oe;
  logic [4:0] timer_clear;
  logic adc_start, irq;
  ccpms_tmr_t [4:0] pwm_tmr;
  logic [4:0] seen_clr = 5'h00;
  logic seen_hi = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int adc_n = 0;
  logic [31:0] pt [9] = '{32'h00400102, 32'h00400204, 32'h03404002, 32'h04410104, 32'h07418008,
    32'h08420108, 32'h09420810, 32'h09420001, 32'h00400300};
  // Mode, flag, out, out checked, converter enabled
  logic [7:0] ct [8] = '{8'h8e, 8'h9a, 8'h26, 8'h10, 8'h30, 8'ha8, 8'hb9, 8'hb8};

  ccpms_top DUT (.ref_clk, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .ccp_in, .ccp_out, .ccp_oe,
    .t1_cnt, .t5_cnt, .pwm_tmr, .timer_clear, .adc_en, .adc_start, .irq);
  ccpms_far_model far (.ref_clk, .arst_n, .timer_clear, .pwm_tmr);

  initial forever #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    seen_clr <= seen_clr | timer_clear;
    if (ccp_out[0]) seen_hi <= 1'b1;
    if (adc_start) adc_n <= adc_n + 1;
  end
  // ----------------------------------------
  // Access and checking tasks
  // ----------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    // Read data stand in this cycle; sampled at its closing edge
    @(posedge ref_clk);
    cmp({8'h00, rdata}, {8'h00, e});
  endtask : rd_chk
  task automatic pulses(input int n);
    repeat (n) begin
      ccp_in[0] <= 1'b1;
      cyc(6);
      ccp_in[0] <= 1'b0;
      cyc(6);
    end
  endtask : pulses
  task automatic clr_seen;
    @(negedge ref_clk);
    seen_clr = 5'h00;
    seen_hi = 1'b0;
  endtask : clr_seen
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd_chk(8'h00, 8'h00);
    rd_chk(`CCPMS_A_TSEL1, 8'h00);
    wr_reg(`CCPMS_A_TSEL2, 8'hff);
    rd_chk(`CCPMS_A_TSEL2, 8'h0f);
    wr_reg(8'h00, 8'hf0);
    rd_chk(8'h00, 8'h30);
    rd_chk(8'h30, 8'h00);
    wr_reg(`CCPMS_A_TSEL0, 8'h03);
    t5_cnt <= 16'h5a6b;
    wr_reg(8'h00, {4'h0, `CCPMS_M_CAP_FALL});
    ccp_in[0] <= 1'b1;
    cyc(6);
    rd_chk(`CCPMS_A_FLAG_LO, 8'h00);
    ccp_in[0] <= 1'b0;
    cyc(6);
    rd_chk(`CCPMS_A_FLAG_LO, 8'h01);
    rd_chk(8'h01, 8'h6b);
    rd_chk(8'h02, 8'h5a);
    wr_reg(`CCPMS_A_FLAG_LO, 8'h01);
    wr_reg(`CCPMS_A_TSEL0, 8'h02);
    t1_cnt <= 16'h1234;
    wr_reg(8'h00, {4'h0, `CCPMS_M_CAP_RISE});
    pulses(1);
    rd_chk(8'h01, 8'h34);
    rd_chk(8'h02, 8'h12);
    cmp({15'h0, irq}, 16'h0000);
    wr_reg(`CCPMS_A_MASK_LO, 8'h01);
    cyc(1);
    cmp({15'h0, irq}, 16'h0001);
    wr_reg(`CCPMS_A_FLAG_LO, 8'h01);
    cyc(1);
    cmp({15'h0, irq}, 16'h0000);
    wr_reg(8'h00, {4'h0, `CCPMS_M_OFF});
    wr_reg(8'h00, {4'h0, `CCPMS_M_CAP_4});
    pulses(3);
    rd_chk(`CCPMS_A_FLAG_LO, 8'h00);
    pulses(1);
    rd_chk(`CCPMS_A_FLAG_LO, 8'h01);
    wr_reg(`CCPMS_A_FLAG_LO, 8'h01);
    wr_reg(8'h00, {4'h0, `CCPMS_M_CAP_16});
    pulses(15);
    rd_chk(`CCPMS_A_FLAG_LO, 8'h00);
    pulses(1);
    rd_chk(`CCPMS_A_FLAG_LO, 8'h01);
    wr_reg(`CCPMS_A_TSEL0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      t1_cnt <= 16'h0000;
      adc_en <= ct[i][0];
      wr_reg(`CCPMS_A_FLAG_LO, 8'h01);
      wr_reg(8'h00, {4'h0, ct[i][7:4]});
      cyc(2);
      t1_cnt <= 16'h1234;
      cyc(4);
      rd_chk(`CCPMS_A_FLAG_LO, {7'h0, ct[i][3]});
      if (ct[i][1]) cmp({15'h0, ccp_out[0]}, {15'h0, ct[i][2]});
    end
    cmp(16'(adc_n), 16'h0001);
    wr_reg(8'h00, {4'h0, `CCPMS_M_OFF});
    // Output clears one edge after the off mode lands
    cyc(2);
    cmp({14'h0, ccp_oe[0], ccp_out[0]}, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      wr_reg(pt[i][23:16], pt[i][15:8]);
      wr_reg(pt[i][31:24] * 8'h04 + 8'h01, 8'h01);
      wr_reg(pt[i][31:24] * 8'h04, {6'h3, i[1:0]});
      clr_seen();
      cyc(1100);
      cmp({11'h0, seen_clr}, {11'h0, pt[i][4:0]});
      wr_reg(pt[i][31:24] * 8'h04, 8'h00);
    end
    // Last entry left channel 0 on the reserved select
    wr_reg(`CCPMS_A_TSEL0, 8'h00);
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h00, 8'h0c);
    clr_seen();
    cyc(1100);
    cmp({15'h0, seen_hi}, 16'h0000);
    wr_reg(8'h00, 8'h3c);
    clr_seen();
    cyc(1100);
    cmp({15'h0, seen_hi}, 16'h0001);
    tally_and_finish();
  end
  initial begin
    // Full run is near 12650 clocks
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : test_ccp_mode_and_timer_select
`default_nettype wire
